// *** dcm_pkg.sv ***
/*
 Package for the debug comparator match block: register offsets, reset
 values, field positions, bank select codes and sequencer states.
 Assumes an APB slave with 32-bit data; printed offsets are word indices,
 so each register's byte address is four times its index.
*/
`default_nettype none
package dcm_pkg;
    // Register indices (byte address = index * 4)
    localparam logic [7:0] DCM_IDX_CTRL = 8'h20;   // Arm, bank select
    localparam logic [7:0] DCM_IDX_STATUS = 8'h21; // Trace full, state
    localparam logic [7:0] DCM_IDX_IRQ_STAT = 8'h22;
    localparam logic [7:0] DCM_IDX_IRQ_MASK = 8'h23;
    localparam logic [7:0] DCM_IDX_SEL_REG = 8'h27; // Bank-selected reg
    localparam logic [7:0] DCM_IDX_WIN_LO = 8'h28;  // Window start
    localparam logic [7:0] DCM_IDX_WIN_HI = 8'h2f;  // Window end
    // Window byte positions within a comparator bank
    localparam logic [2:0] DCM_WIN_CTL = 3'h0;
    localparam logic [2:0] DCM_WIN_ADR_H = 3'h2;
    localparam logic [2:0] DCM_WIN_ADR_M = 3'h3;
    localparam logic [2:0] DCM_WIN_ADR_L = 3'h4;
    localparam logic [2:0] DCM_WIN_DAT_H = 3'h5;
    localparam logic [2:0] DCM_WIN_DAT_L = 3'h6;
    localparam logic [2:0] DCM_WIN_MSK_H = 3'h7;
    // Mask low register lives at window position 1
    localparam logic [2:0] DCM_WIN_MSK_L = 3'h1;
    // Comparator control field positions
    localparam int DCM_CTL_ENABLE = 0;
    localparam int DCM_CTL_RW = 1;   // Expected direction, 1 = read
    localparam int DCM_CTL_RWE = 2;  // direction_qualify_enable
    localparam int DCM_CTL_SZ = 3;   // access_width_select, 1 = byte
    localparam int DCM_CTL_SZE = 4;  // size_compare_enable
    // Control register fields
    localparam int DCM_ARM_BIT = 7;
    localparam int DCM_TRACE_EN_BIT = 6;
    // Status register fields
    localparam int DCM_TBF_BIT = 7;
    localparam logic [7:0] DCM_STATUS_RST = 8'h00;
    localparam logic [7:0] DCM_ZERO8 = 8'h00;
    // Interrupt status bits
    localparam int DCM_IRQ_MATCH = 0;
    localparam int DCM_IRQ_FINAL = 1;
    localparam int DCM_IRQ_FULL = 2;
    // Bank select codes
    localparam logic [1:0] DCM_BANK_A = 2'b00;
    localparam logic [1:0] DCM_BANK_B = 2'b01;
    localparam logic [1:0] DCM_BANK_C = 2'b10;
    localparam logic [1:0] DCM_BANK_NONE = 2'b11;
    // Data mask values
    localparam logic [15:0] DCM_MASK_NONE = 16'h0000;
    // Sequencer states
    typedef enum logic [2:0] {
        DCM_ST_IDLE, DCM_ST_ONE, DCM_ST_TWO, DCM_ST_THREE, DCM_ST_FINAL
    } dcm_state_t;
    // Sequencer state flag codes
    localparam logic [2:0] DCM_SSF_IDLE = 3'h0;
    localparam logic [2:0] DCM_SSF_ONE = 3'h1;
    localparam logic [2:0] DCM_SSF_TWO = 3'h2;
    localparam logic [2:0] DCM_SSF_THREE = 3'h3;
    localparam logic [2:0] DCM_SSF_FINAL = 3'h4;
    localparam int DCM_TRACE_DEPTH = 64;
endpackage : dcm_pkg
`default_nettype wire

// *** dcm_comparator.sv ***
/*
 One watchpoint comparator channel: address, direction, size and,
 optionally, data byte comparison against a monitored core bus access.
 Assumes bus signals are synchronous to clk_sys and the byte at the
 access address sits in bus_data[15:8] on word accesses.
*/
`default_nettype none
module dcm_comparator
    import dcm_pkg::*;
#(
    parameter int ADDR_W = 18,
    parameter bit HAS_DATA = 1'b0
) (
    input wire logic [7:0] ctl,
    input wire logic [ADDR_W-1:0] cmp_addr,
    input wire logic [7:0] dat_h,
    input wire logic [7:0] dat_l,
    input wire logic [15:0] dmask,
    input wire logic bus_valid,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic bus_read,
    input wire logic bus_byte,
    input wire logic [15:0] bus_data,
    output logic hit
);
    logic addr_ok;  // Exact start address only
    logic dir_ok;   // Direction qualifier
    logic size_ok;  // Access size qualifier
    logic data_ok;  // Data byte qualifier
    // Match logic; combinational, registered by the parent
    always_comb begin
        // A word at addr-1 also covers addr, yet must never hit
        addr_ok = (bus_addr == cmp_addr); // see R3 see R5
        dir_ok = !ctl[DCM_CTL_RWE] ||
                 (bus_read == ctl[DCM_CTL_RW]); // see R7
        // Size check off: both widths hit; on: SZ bit picks one
        size_ok = !ctl[DCM_CTL_SZE] ||
                  (bus_byte == ctl[DCM_CTL_SZ]); // see R4
        data_ok = 1'b1;
        if (HAS_DATA) begin
            // Lower address byte against high compare reg
            if (dmask[15:8] != DCM_ZERO8 &&
                ((bus_data[15:8] & dmask[15:8]) !=
                 (dat_h & dmask[15:8]))) begin
                data_ok = 1'b0; // see R9 see R10 see R15
            end
            // Next address byte; ignored on byte-only matching
            if (dmask[7:0] != DCM_ZERO8 &&
                !(ctl[DCM_CTL_SZE] && ctl[DCM_CTL_SZ]) &&
                ((bus_data[7:0] & dmask[7:0]) !=
                 (dat_l & dmask[7:0]))) begin
                data_ok = 1'b0; // see R9 see R10 see R15
            end
        end
        hit = ctl[DCM_CTL_ENABLE] && bus_valid && addr_ok &&
              dir_ok && size_ok && data_ok; // see R8
    end
endmodule // dcm_comparator
`default_nettype wire

// *** dcm_top.sv ***
/*
 Debug comparator match block: three watchpoint comparators, a priority
 resolved state sequencer, trace fill tracking, APB register file and a
 level interrupt. Assumes APB master on clk_sys and a monitored core bus
 presenting one access per cycle qualified by bus_valid.
*/
// The APB slave port was chosen for this implementation.
`default_nettype none
// Contract
// R1: Bank select maps A,B,C,none to registers
// R2: Status shows trace full, state flags
// R3: Byte match ignores word covering address
// R4: Comparator B size compare per SZ8
// R5: Word at address minus one never matches
// R6: Software programs exact access address
// R7: Direction qualifies A and B too
// R8: A compares address, direction, size, data
// R9: Word data: low address to high reg
// R10: Data mask selects compared bytes
// R11: Lowest channel wins simultaneous matches
// R12: Bank select steers window and 0x27
// R13: Arm enters State1; auto clears
// R14: Flags encode state; trace full sticks
// R15: Byte-only data compares high register only
module dcm_top
    import dcm_pkg::*;
#(
    parameter int ADDR_W = 18,
    parameter int TRACE_DEPTH = DCM_TRACE_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bus_valid,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic bus_read,
    input wire logic bus_byte,
    input wire logic [15:0] bus_data,
    output logic brk_req,
    output logic irq
);
    // Per-comparator configuration, index 0..2 = A..C
    logic [7:0] ctl_ff [3];
    logic [7:0] nxt_ctl [3];
    logic [ADDR_W-1:0] adr_ff [3];
    logic [ADDR_W-1:0] nxt_adr [3];
    logic [7:0] dh_ff, nxt_dh, dl_ff, nxt_dl;
    logic [15:0] msk_ff, nxt_msk;
    logic [7:0] dctl_ff, nxt_dctl;     // Arm, trace enable, bank select
    logic [7:0] scr_ff [3];            // State control regs one..three
    logic [7:0] nxt_scr [3];
    logic [2:0] mflag_ff, nxt_mflag;   // Match flag register
    logic [2:0] ist_ff, nxt_ist;       // Interrupt status
    logic [2:0] imsk_ff, nxt_imsk;     // Interrupt mask
    logic tbf_ff, nxt_tbf;             // trace_full_flag
    logic [$clog2(TRACE_DEPTH+1)-1:0] tcnt_ff, nxt_tcnt;
    dcm_state_t st_ff, nxt_st;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic brk_ff, nxt_brk, irq_ff, nxt_irq;
    logic [2:0] hit;                   // Raw comparator hits
    logic [1:0] win_chan;              // Winning channel
    logic win_any;
    logic [2:0] sequencer_state_flags;
    logic wr, rd, mapped;
    logic [7:0] idx;
    logic [7:0] rval;

    // Byte address to register index; low bits must be zero
    function automatic logic [7:0] reg_idx(input logic [11:0] a);
        return a[9:2];
    endfunction

    // Sequencer state to flag code
    function automatic logic [2:0] st_code(input dcm_state_t s);
        case (s)
            DCM_ST_ONE: return DCM_SSF_ONE;
            DCM_ST_TWO: return DCM_SSF_TWO;
            DCM_ST_THREE: return DCM_SSF_THREE;
            DCM_ST_FINAL: return DCM_SSF_FINAL;
            default: return DCM_SSF_IDLE;
        endcase
    endfunction

    // Comparators; only A has data comparison
    for (genvar g = 0; g < 3; g++) begin : g_cmp
        dcm_comparator #(
            .ADDR_W(ADDR_W),
            .HAS_DATA(g == 0)
        ) u_cmp (
            .ctl(ctl_ff[g]),
            .cmp_addr(adr_ff[g]),
            .dat_h(dh_ff),
            .dat_l(dl_ff),
            .dmask(msk_ff),
            .bus_valid(bus_valid),
            .bus_addr(bus_addr),
            .bus_read(bus_read),
            .bus_byte(bus_byte),
            .bus_data(bus_data),
            .hit(hit[g])
        );
    end

    // Priority: lowest channel wins, others dropped
    always_comb begin
        win_any = |hit;
        win_chan = 2'd0; // see R11
        if (hit[0]) begin
            win_chan = 2'd0;
        end else if (hit[1]) begin
            win_chan = 2'd1;
        end else if (hit[2]) begin
            win_chan = 2'd2;
        end
        sequencer_state_flags = st_code(st_ff); // see R14
    end

    // APB decode and read mux
    always_comb begin
        idx = reg_idx(paddr);
        wr = psel && penable && pwrite && !pready_ff;
        rd = psel && penable && !pwrite && !pready_ff;
        mapped = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
                 (idx == DCM_IDX_CTRL || idx == DCM_IDX_STATUS ||
                  idx == DCM_IDX_IRQ_STAT || idx == DCM_IDX_IRQ_MASK ||
                  idx == DCM_IDX_SEL_REG ||
                  (idx >= DCM_IDX_WIN_LO && idx <= DCM_IDX_WIN_HI));
        rval = DCM_ZERO8;
        if (idx == DCM_IDX_CTRL) begin
            rval = dctl_ff;
        end else if (idx == DCM_IDX_STATUS) begin
            rval = {tbf_ff, 4'h0, sequencer_state_flags}; // see R2
        end else if (idx == DCM_IDX_IRQ_STAT) begin
            rval = {5'h00, ist_ff};
        end else if (idx == DCM_IDX_IRQ_MASK) begin
            rval = {5'h00, imsk_ff};
        end else if (idx == DCM_IDX_SEL_REG) begin
            // Which register shows here follows bank select
            case (dctl_ff[1:0]) // see R1 see R12
                DCM_BANK_A: rval = scr_ff[0];
                DCM_BANK_B: rval = scr_ff[1];
                DCM_BANK_C: rval = scr_ff[2];
                default: rval = {5'h00, mflag_ff};
            endcase
        end else if (mapped && dctl_ff[1:0] != DCM_BANK_NONE) begin
            // Window shows the selected comparator bank
            case (idx[2:0]) // see R12
                DCM_WIN_CTL: rval = ctl_ff[dctl_ff[1:0]];
                DCM_WIN_ADR_H:
                    rval = 8'(adr_ff[dctl_ff[1:0]] >> 16);
                DCM_WIN_ADR_M: rval = adr_ff[dctl_ff[1:0]][15:8];
                DCM_WIN_ADR_L: rval = adr_ff[dctl_ff[1:0]][7:0];
                DCM_WIN_DAT_H: rval = (dctl_ff[1:0] == DCM_BANK_A) ?
                                      dh_ff : DCM_ZERO8;
                DCM_WIN_DAT_L: rval = (dctl_ff[1:0] == DCM_BANK_A) ?
                                      dl_ff : DCM_ZERO8;
                DCM_WIN_MSK_H: rval = (dctl_ff[1:0] == DCM_BANK_A) ?
                                      msk_ff[15:8] : DCM_ZERO8;
                default: rval = (dctl_ff[1:0] == DCM_BANK_A) ?
                                msk_ff[7:0] : DCM_ZERO8;
            endcase
        end
    end

    // Register writes, sequencer, flags and bus answer
    always_comb begin
        nxt_ctl = ctl_ff;
        nxt_adr = adr_ff;
        nxt_scr = scr_ff;
        nxt_dh = dh_ff;
        nxt_dl = dl_ff;
        nxt_msk = msk_ff;
        nxt_dctl = dctl_ff;
        nxt_imsk = imsk_ff;
        nxt_mflag = mflag_ff;
        nxt_ist = ist_ff;
        nxt_tbf = tbf_ff;
        nxt_tcnt = tcnt_ff;
        nxt_st = st_ff;
        nxt_brk = 1'b0;
        // Answer one cycle into the access phase
        nxt_pready = psel && penable && !pready_ff;
        nxt_pslverr = (wr || rd) && !mapped;
        nxt_prdata = rd ? {24'h000000, rval} : 32'h00000000;
        // Reading interrupt status clears it
        if (rd && mapped && idx == DCM_IDX_IRQ_STAT) begin
            nxt_ist = 3'h0;
        end
        if (wr && mapped) begin
            if (idx == DCM_IDX_CTRL) begin
                nxt_dctl = pwdata[7:0];
                if (pwdata[DCM_ARM_BIT] && !dctl_ff[DCM_ARM_BIT]) begin
                    nxt_st = DCM_ST_ONE; // see R13
                    nxt_tcnt = '0;
                    nxt_tbf = 1'b0;
                    nxt_mflag = 3'h0;
                end
                if (!pwdata[DCM_ARM_BIT]) begin
                    nxt_st = DCM_ST_IDLE;
                end
            end else if (idx == DCM_IDX_IRQ_MASK) begin
                nxt_imsk = pwdata[2:0];
            end else if (idx == DCM_IDX_SEL_REG) begin
                if (dctl_ff[1:0] != DCM_BANK_NONE) begin
                    nxt_scr[dctl_ff[1:0]] = pwdata[7:0]; // see R1
                end
            end else if (idx >= DCM_IDX_WIN_LO &&
                         dctl_ff[1:0] != DCM_BANK_NONE) begin
                // Software must load the exact access address
                case (idx[2:0]) // see R6 see R12
                    DCM_WIN_CTL: nxt_ctl[dctl_ff[1:0]] = pwdata[7:0];
                    DCM_WIN_ADR_H: nxt_adr[dctl_ff[1:0]] =
                        ADDR_W'({pwdata[7:0], adr_ff[dctl_ff[1:0]][15:0]});
                    DCM_WIN_ADR_M:
                        nxt_adr[dctl_ff[1:0]][15:8] = pwdata[7:0];
                    DCM_WIN_ADR_L:
                        nxt_adr[dctl_ff[1:0]][7:0] = pwdata[7:0];
                    DCM_WIN_DAT_H: if (dctl_ff[1:0] == DCM_BANK_A) begin
                        nxt_dh = pwdata[7:0];
                    end
                    DCM_WIN_DAT_L: if (dctl_ff[1:0] == DCM_BANK_A) begin
                        nxt_dl = pwdata[7:0];
                    end
                    DCM_WIN_MSK_H: if (dctl_ff[1:0] == DCM_BANK_A) begin
                        nxt_msk[15:8] = pwdata[7:0];
                    end
                    default: if (dctl_ff[1:0] == DCM_BANK_A) begin
                        nxt_msk[7:0] = pwdata[7:0];
                    end
                endcase
            end
        end
        // Trace fills one entry per winning match while armed
        if (dctl_ff[DCM_ARM_BIT] && dctl_ff[DCM_TRACE_EN_BIT] &&
            win_any && !tbf_ff) begin
            nxt_tcnt = tcnt_ff + 1'b1;
            if (tcnt_ff == ($bits(tcnt_ff))'(TRACE_DEPTH - 1)) begin
                nxt_tbf = 1'b1; // see R14
                nxt_ist[DCM_IRQ_FULL] = 1'b1;
            end
        end
        // Sequencer steps on the winning channel only
        if (dctl_ff[DCM_ARM_BIT] && win_any) begin
            nxt_mflag[win_chan] = 1'b1; // see R11
            nxt_ist[DCM_IRQ_MATCH] = 1'b1;
            case (st_ff)
                DCM_ST_ONE: nxt_st = (win_chan == 2'd0) ? DCM_ST_FINAL :
                                     DCM_ST_TWO;
                DCM_ST_TWO: nxt_st = (win_chan == 2'd2) ? DCM_ST_FINAL :
                                     DCM_ST_THREE;
                DCM_ST_THREE: nxt_st = DCM_ST_FINAL;
                default: nxt_st = st_ff;
            endcase
        end
        // Final state: end session, break if not tracing or full
        if (st_ff == DCM_ST_FINAL && dctl_ff[DCM_ARM_BIT] &&
            (!dctl_ff[DCM_TRACE_EN_BIT] || tbf_ff)) begin
            nxt_dctl[DCM_ARM_BIT] = 1'b0; // see R13
            nxt_brk = 1'b1;
            nxt_st = DCM_ST_IDLE;
            nxt_ist[DCM_IRQ_FINAL] = 1'b1;
        end
        nxt_irq = |(nxt_ist & imsk_ff);
    end

    // State registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                ctl_ff[i] <= 8'h00;
                adr_ff[i] <= '0;
                scr_ff[i] <= 8'h00;
            end
            dh_ff <= 8'h00;
            dl_ff <= 8'h00;
            msk_ff <= DCM_MASK_NONE;
            dctl_ff <= 8'h00;
            imsk_ff <= 3'h0;
            mflag_ff <= 3'h0;
            ist_ff <= 3'h0;
            tbf_ff <= DCM_STATUS_RST[DCM_TBF_BIT];
            tcnt_ff <= '0;
            st_ff <= DCM_ST_IDLE;
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            brk_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            ctl_ff <= nxt_ctl;
            adr_ff <= nxt_adr;
            scr_ff <= nxt_scr;
            dh_ff <= nxt_dh;
            dl_ff <= nxt_dl;
            msk_ff <= nxt_msk;
            dctl_ff <= nxt_dctl;
            imsk_ff <= nxt_imsk;
            mflag_ff <= nxt_mflag;
            ist_ff <= nxt_ist;
            tbf_ff <= nxt_tbf;
            tcnt_ff <= nxt_tcnt;
            st_ff <= nxt_st;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            brk_ff <= nxt_brk;
            irq_ff <= nxt_irq;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign brk_req = brk_ff;
    assign irq = irq_ff;

    // Checks
    arm_state1_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr && mapped && idx == DCM_IDX_CTRL && pwdata[DCM_ARM_BIT] &&
        !dctl_ff[DCM_ARM_BIT] |=> st_ff == DCM_ST_ONE) // see R13
        else $error("arming did not enter state one");
    prio_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        dctl_ff[DCM_ARM_BIT] && hit[0] && hit[1] && st_ff == DCM_ST_ONE
        && !wr |=> st_ff == DCM_ST_FINAL) // see R11
        else $error("lower channel lost priority");
    status_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd && idx == DCM_IDX_STATUS |=> prdata[6:3] == 4'h0 &&
        prdata[2:0] == $past(sequencer_state_flags)) // see R2
        else $error("status read wrong");
    size_b_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        hit[1] && ctl_ff[1][DCM_CTL_SZE] |->
        bus_byte == ctl_ff[1][DCM_CTL_SZ]) // see R4
        else $error("comparator B size mismatch");
    exact_adr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        |hit |-> bus_addr == adr_ff[win_chan]) // see R3 see R5
        else $error("hit on wrong address");
    dir_qual_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        hit[0] && ctl_ff[0][DCM_CTL_RWE] |->
        bus_read == ctl_ff[0][DCM_CTL_RW]) // see R7
        else $error("direction not qualified");
    data_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        hit[0] && msk_ff == 16'hff00 |-> bus_data[15:8] == dh_ff)
        else $error("high data byte mismatch"); // see R9 see R10
    tbf_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tbf_ff && !wr |=> tbf_ff) // see R14
        else $error("trace full dropped");
    irq_level_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 irq == |($past(nxt_ist) & $past(imsk_ff)))
        else $error("interrupt level wrong");
    arm_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_ff == DCM_ST_FINAL && dctl_ff[DCM_ARM_BIT] &&
        !dctl_ff[DCM_TRACE_EN_BIT] |=> !dctl_ff[DCM_ARM_BIT] && brk_req)
        else $error("arm not cleared at end"); // see R13
    match_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        dctl_ff[DCM_ARM_BIT] && win_any);
    brk_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        brk_req);
    full_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(tbf_ff));
endmodule // dcm_top
`default_nettype wire

// *** dcm_core_model.sv ***
/*
 Core bus partner for the debug comparator block: one monitored access
 per call. Assumes calls start just after a rising edge of clk_sys.
*/
`default_nettype none
module dcm_core_model (
    input wire logic clk_sys,
    output logic bus_valid,
    output logic [17:0] bus_addr,
    output logic bus_read,
    output logic bus_byte,
    output logic [15:0] bus_data
);
    timeunit 1ns;
    timeprecision 1ns;
    // Quiet bus at time zero
    initial begin
        bus_valid = 1'b0;
        bus_addr = 18'h0;
        bus_read = 1'b0;
        bus_byte = 1'b0;
        bus_data = 16'h0;
    end
    // Access stands one cycle; then the lines show the inverse, so a
    // stale value can never pass for a fresh access
    task automatic access(input logic [17:0] a, input logic rd,
                          input logic bt, input logic [15:0] d);
        bus_valid <= 1'b1;
        bus_addr <= a;
        bus_read <= rd;
        bus_byte <= bt;
        bus_data <= d;
        @(posedge clk_sys);
        bus_valid <= 1'b0;
        bus_addr <= ~a;
        bus_read <= ~rd;
        bus_byte <= ~bt;
        bus_data <= ~d;
    endtask
endmodule // dcm_core_model
`default_nettype wire

// *** dcm_top_bench.sv ***
/*
 Self-checking bench for dcm_top: APB register traffic and core bus
 accesses. Assumes dcm_pkg, dcm_top and dcm_core_model compile first.
*/
`default_nettype none
module dcm_top_bench
    import dcm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0] bk;
        logic [7:0] ct;
        logic [15:0] mk;
        logic [17:0] ad;
        logic rd;
        logic bt;
        logic [15:0] dt;
        logic ex;
    } dcm_row_t;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, rerr, bus_valid, bus_read, bus_byte;
    logic brk_req, irq;
    logic [17:0] bus_addr;
    logic [15:0] bus_data;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0; // Hang limit counter
    int brk_cnt = 0; // Breakpoint pulses seen
    // Bank, control, mask, access, expected match
    dcm_row_t rows [16] = '{
        '{2'h1, 8'h01, 16'h0, 18'h01234, 1'b1, 1'b1, 16'h0, 1'b1},
        '{2'h1, 8'h01, 16'h0, 18'h01234, 1'b1, 1'b0, 16'h0, 1'b1},
        '{2'h1, 8'h11, 16'h0, 18'h01234, 1'b1, 1'b0, 16'h0, 1'b1},
        '{2'h1, 8'h11, 16'h0, 18'h01234, 1'b1, 1'b1, 16'h0, 1'b0},
        '{2'h1, 8'h19, 16'h0, 18'h01234, 1'b1, 1'b1, 16'h0, 1'b1},
        '{2'h1, 8'h19, 16'h0, 18'h01234, 1'b1, 1'b0, 16'h0, 1'b0},
        '{2'h1, 8'h01, 16'h0, 18'h01233, 1'b1, 1'b0, 16'h0, 1'b0},
        '{2'h1, 8'h07, 16'h0, 18'h01234, 1'b1, 1'b0, 16'h0, 1'b1},
        '{2'h1, 8'h07, 16'h0, 18'h01234, 1'b0, 1'b0, 16'h0, 1'b0},
        '{2'h0, 8'h01, 16'hff00, 18'h01234, 1'b1, 1'b0, 16'ha5ff, 1'b1},
        '{2'h0, 8'h01, 16'hff00, 18'h01234, 1'b1, 1'b0, 16'h5aff, 1'b0},
        '{2'h0, 8'h01, 16'h00ff, 18'h01234, 1'b1, 1'b0, 16'hff3c, 1'b1},
        '{2'h0, 8'h01, 16'hffff, 18'h01234, 1'b1, 1'b0, 16'h3ca5, 1'b0},
        '{2'h0, 8'h19, 16'hffff, 18'h01234, 1'b1, 1'b1, 16'ha500, 1'b1},
        '{2'h0, 8'h05, 16'h0, 18'h01234, 1'b1, 1'b0, 16'h0, 1'b0},
        '{2'h2, 8'h01, 16'h0, 18'h01234, 1'b0, 1'b1, 16'h0, 1'b1}
    };
    dcm_top #(.ADDR_W(18), .TRACE_DEPTH(4)) uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus_valid(bus_valid),
        .bus_addr(bus_addr), .bus_read(bus_read), .bus_byte(bus_byte),
        .bus_data(bus_data), .brk_req(brk_req), .irq(irq));
    dcm_core_model core (
        .clk_sys(clk_sys), .bus_valid(bus_valid), .bus_addr(bus_addr),
        .bus_read(bus_read), .bus_byte(bus_byte), .bus_data(bus_data));
    // 50 MHz clock
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    // Count breakpoint pulses; cut a hang short
    always @(posedge clk_sys) begin
        cyc++;
        if (brk_req === 1'b1) brk_cnt++;
        if (cyc == 20000) begin
            err_total++;
            $display("BAD %0t hang limit reached", $time);
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready, then an idle cycle
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wwin(input logic [2:0] pos, input logic [7:0] v);
        apb(1'b1, DCM_IDX_WIN_LO + {5'h0, pos}, v);
    endtask
    // Program one channel at address 0x01234, then arm
    task automatic prog(input logic [1:0] bk, input logic [7:0] ct,
                        input logic [15:0] mk);
        apb(1'b1, DCM_IDX_CTRL, {6'h0, bk});
        wwin(DCM_WIN_CTL, ct);
        wwin(DCM_WIN_MSK_L, mk[7:0]);
        wwin(DCM_WIN_MSK_H, mk[15:8]);
        wwin(DCM_WIN_ADR_H, 8'h00);
        wwin(DCM_WIN_ADR_M, 8'h12);
        wwin(DCM_WIN_ADR_L, 8'h34);
        apb(1'b1, DCM_IDX_CTRL, {6'h20, bk});
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, DCM_IDX_STATUS, 8'h0);
        chk(rdat, 32'h0);
        apb(1'b1, DCM_IDX_STATUS, 8'hff);
        apb(1'b0, DCM_IDX_STATUS, 8'h0);
        chk(rdat, 32'h0);
        apb(1'b0, 8'h24, 8'h0);
        chk({31'h0, rerr}, 32'h1);
        // Data compare values for channel A
        apb(1'b1, DCM_IDX_CTRL, {6'h0, DCM_BANK_A});
        wwin(DCM_WIN_DAT_H, 8'ha5);
        wwin(DCM_WIN_DAT_L, 8'h3c);
        foreach (rows[i]) begin
            prog(rows[i].bk, rows[i].ct, rows[i].mk);
            apb(1'b0, DCM_IDX_IRQ_STAT, 8'h0);
            core.access(rows[i].ad, rows[i].rd, rows[i].bt, rows[i].dt);
            apb(1'b0, DCM_IDX_IRQ_STAT, 8'h0);
            chk({31'h0, rdat[0]}, {31'h0, rows[i].ex});
            wwin(DCM_WIN_CTL, 8'h00);
        end
        // Sequencer steps and the interrupt path
        apb(1'b1, DCM_IDX_IRQ_MASK, 8'h01);
        prog(DCM_BANK_B, 8'h01, 16'h0);
        apb(1'b0, DCM_IDX_STATUS, 8'h0);
        chk(rdat, 32'h1);
        core.access(18'h01234, 1'b1, 1'b0, 16'h0);
        apb(1'b0, DCM_IDX_STATUS, 8'h0);
        chk(rdat, 32'h2);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, DCM_IDX_IRQ_STAT, 8'h0);
        chk({31'h0, irq}, 32'h0);
        // A and B hit together: A wins, so final and a breakpoint
        prog(DCM_BANK_A, 8'h01, 16'h0);
        prog(DCM_BANK_B, 8'h01, 16'h0);
        brk_cnt = 0;
        core.access(18'h01234, 1'b1, 1'b0, 16'h0);
        repeat (4) @(posedge clk_sys);
        chk(brk_cnt, 32'h1);
        apb(1'b0, DCM_IDX_CTRL, 8'h0);
        chk({31'h0, rdat[7]}, 32'h0);
        // Register at 0x27 follows the bank select
        apb(1'b1, DCM_IDX_CTRL, {6'h0, DCM_BANK_A});
        apb(1'b1, DCM_IDX_SEL_REG, 8'h03);
        apb(1'b1, DCM_IDX_CTRL, {6'h0, DCM_BANK_B});
        apb(1'b1, DCM_IDX_SEL_REG, 8'h05);
        apb(1'b1, DCM_IDX_CTRL, {6'h0, DCM_BANK_A});
        apb(1'b0, DCM_IDX_SEL_REG, 8'h0);
        chk(rdat, 32'h3);
        // Bank none shows match flags: only A won the double hit
        apb(1'b1, DCM_IDX_CTRL, {6'h0, DCM_BANK_NONE});
        apb(1'b0, DCM_IDX_SEL_REG, 8'h0);
        chk(rdat, 32'h1);
        // Tracing on: four hits fill the trace, then the session ends
        apb(1'b1, DCM_IDX_CTRL, {6'h0, DCM_BANK_B});
        apb(1'b1, DCM_IDX_CTRL, {6'h30, DCM_BANK_B});
        repeat (4) begin
            core.access(18'h01234, 1'b1, 1'b0, 16'h0);
            @(posedge clk_sys);
        end
        apb(1'b0, DCM_IDX_STATUS, 8'h0);
        chk(rdat, 32'h80);
        stop_test();
    end
endmodule // dcm_top_bench
`default_nettype wire
